// File: hdl/i2c_control_register.v
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "i2c_ctrl_defs.vh"
module i2c_control_register (
   input wire CLOCK,
   input wire RESETN,
   input wire [7:0] ADDR,
   input wire [31:0] WDATA,
   input wire WRITE,
   input wire READ,
   output reg [31:0] RDATA,
   input wire IDLE_MODE,
   input wire SDA_IN,
   input wire SCL_IN,
   output reg SDA_OUT,
   output reg SDA_OE,
   output reg SCL_OUT,
   output reg SCL_OE,
   output reg PINS_OWNED,
   output reg SLEW_LIMIT_OFF,
   output reg SMBUS_THRESHOLD_SELECT
);
   localparam M_IDLE = 3'd0, M_START = 3'd1, M_RSTART = 3'd2, M_STOP = 3'd3;
   localparam M_RX = 3'd4, M_TX = 3'd5, M_ACK = 3'd6;
   localparam S_IDLE = 3'd0, S_ADDR = 3'd1, S_ADDR2 = 3'd2, S_RX = 3'd3, S_TX = 3'd4;

   reg [15:0] ctl_q;
   reg [9:0] own_q;
   reg [15:0] baud_q;
   reg [7:0] tx_q;
   reg [7:0] rx_q;
   reg rx_full_q, refused_q, ack_in_q, busy_q, tx_pend_q, first_q;
   reg [2:0] m_st_q;
   reg [1:0] ph_q;
   reg [3:0] m_bit_q;
   reg [7:0] m_sh_q;
   reg m_sda_q, m_scl_q;
   reg [15:0] brg_q;
   reg [2:0] s_st_q;
   reg [3:0] s_cnt_q;
   reg [7:0] s_sh_q;
   reg s_sda_q, s_rw_q, s_match_q, s_wide_hit_q, s_nack_q;
   reg [1:0] sda_sync_q, scl_sync_q;
   reg sda_p_q, scl_p_q;

   wire en = ctl_q[`B_ENABLE];
   wire stretch_enable = ctl_q[`B_STRETCH];
   wire run = en & ~(IDLE_MODE & ctl_q[`B_IDLE_STOP]);
   wire sda_s = sda_sync_q[1];
   wire scl_s = scl_sync_q[1];
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire tick = (brg_q == 16'h0000);
   wire stall = (ph_q == 2'd2) & ~scl_s; // Other party stretching our clock
   wire step = run & (m_st_q != M_IDLE) & tick & ~stall;
   wire wr_ctl = WRITE & (ADDR == `OFS_CONTROL);
   wire wr_tx = WRITE & (ADDR == `OFS_TX_DATA);
   wire [6:0] addr7 = s_sh_q[7:1];
   wire reserved7 = (addr7[6:3] == 4'h0) | (addr7[6:3] == 4'hF);
   wire tx_reserved = (WDATA[7:4] == 4'h0) | (WDATA[7:4] == 4'hF);
   // Slave address decision at the eighth bit
   wire gc_hit = (s_sh_q == 8'h00) & ctl_q[`B_GC_ACCEPT];
   wire hit7 = ~ctl_q[`B_WIDE] & (addr7 == own_q[6:0]) & ~reserved7;
   wire hit7_any = (hit7 | gc_hit) & ~(ctl_q[`B_STRICT] & reserved7);
   wire hit10 = ctl_q[`B_WIDE] & (s_sh_q[7:3] == 5'b11110)
                & (s_sh_q[2:1] == own_q[9:8]);
   // Hardware events on the clock release bit
   wire s_bytedone = run & scl_fall & (s_cnt_q == 4'd9);
   wire tx_begin = s_bytedone & s_match_q & ((s_st_q == S_ADDR & s_rw_q)
                   | (s_st_q == S_TX & ~s_nack_q));
   wire rx_end = s_bytedone & (s_st_q == S_RX);
   wire rel_clr = tx_begin | (rx_end & stretch_enable);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge history
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         sda_sync_q <= 2'b11;
         scl_sync_q <= 2'b11;
         sda_p_q <= 1'b1;
         scl_p_q <= 1'b1;
      end else begin
         sda_sync_q <= {sda_sync_q[0], SDA_IN};
         scl_sync_q <= {scl_sync_q[0], SCL_IN};
         sda_p_q <= sda_s;
         scl_p_q <= scl_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register writes; software writes beat completion clears on sequence bits
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ctl_q <= `CONTROL_RESET;
         own_q <= 10'h000;
         baud_q <= `BAUD_RESET;
         tx_q <= 8'h00;
      end else begin
         if (step & (ph_q == 2'd3)) begin
            if (m_st_q == M_START) ctl_q[`B_START] <= 1'b0;
            if (m_st_q == M_RSTART) ctl_q[`B_RSTART] <= 1'b0;
            if (m_st_q == M_STOP) ctl_q[`B_STOP] <= 1'b0;
            if (m_st_q == M_ACK) ctl_q[`B_ACK_SEND] <= 1'b0;
            if (m_st_q == M_RX && m_bit_q == 4'd7) ctl_q[`B_RECEIVE] <= 1'b0;
         end
         if (!en) ctl_q[4:0] <= 5'b00000; // Pending actions die with the module
         if (wr_ctl) begin
            ctl_q[15] <= WDATA[15];
            ctl_q[13] <= WDATA[13];
            ctl_q[11:0] <= WDATA[11:0];
            // Stretch on: plain write; off: only a one takes effect
            ctl_q[`B_RELEASE] <= stretch_enable ? WDATA[`B_RELEASE]
                                : (ctl_q[`B_RELEASE] | WDATA[`B_RELEASE]);
         end
         if (rel_clr) ctl_q[`B_RELEASE] <= 1'b0;
         if (WRITE && ADDR == `OFS_OWN_ADDR) own_q <= WDATA[9:0];
         if (WRITE && ADDR == `OFS_BAUD) baud_q <= WDATA[15:0];
         if (wr_tx) tx_q <= WDATA[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read port and read side effects
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= 32'h0000_0000;
      end else begin
         RDATA <= 32'h0000_0000;
         if (READ) begin
            if (ADDR == `OFS_CONTROL) RDATA <= {16'h0000, ctl_q[15], 1'b0, ctl_q[13:0]};
            else if (ADDR == `OFS_OWN_ADDR) RDATA <= {22'h00_0000, own_q};
            else if (ADDR == `OFS_BAUD) RDATA <= {16'h0000, baud_q};
            else if (ADDR == `OFS_STATUS)
               RDATA <= {25'h000_0000, busy_q, refused_q, rx_full_q, ack_in_q, s_rw_q,
                         s_st_q != S_IDLE, m_st_q != M_IDLE | tx_pend_q};
            else if (ADDR == `OFS_RX_DATA) RDATA <= {24'h00_0000, rx_q};
            else RDATA <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Master bit engine: four quarter-bit phases per bit, one phase per step
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         m_st_q <= M_IDLE;
         ph_q <= 2'd0;
         m_bit_q <= 4'd0;
         m_sh_q <= 8'h00;
         m_sda_q <= 1'b0;
         m_scl_q <= 1'b0;
         brg_q <= 16'h0000;
         tx_pend_q <= 1'b0;
         first_q <= 1'b0;
         refused_q <= 1'b0;
         ack_in_q <= 1'b0;
      end else if (!en) begin
         m_st_q <= M_IDLE;
         ph_q <= 2'd0;
         m_sda_q <= 1'b0;
         m_scl_q <= 1'b0;
         tx_pend_q <= 1'b0;
         first_q <= 1'b0;
      end else begin
         // Our own start puts the slave side in address state, so that must not block us
         if (wr_tx && (s_st_q == S_IDLE || s_st_q == S_ADDR)) begin
            // Refuse a reserved address as the first byte after a start
            if (first_q && ctl_q[`B_STRICT] && tx_reserved) refused_q <= 1'b1;
            else tx_pend_q <= 1'b1;
         end
         if (wr_ctl) refused_q <= 1'b0;
         if (run && !stall) brg_q <= tick ? baud_q : brg_q - 16'h0001;
         if (run && m_st_q == M_IDLE) begin
            ph_q <= 2'd0;
            m_bit_q <= 4'd0;
            brg_q <= baud_q;
            if (ctl_q[`B_START]) m_st_q <= M_START;
            else if (ctl_q[`B_RSTART]) m_st_q <= M_RSTART;
            else if (ctl_q[`B_STOP]) m_st_q <= M_STOP;
            else if (ctl_q[`B_RECEIVE]) m_st_q <= M_RX;
            else if (ctl_q[`B_ACK_SEND]) m_st_q <= M_ACK;
            else if (tx_pend_q) begin
               m_st_q <= M_TX;
               m_sh_q <= tx_q;
               tx_pend_q <= 1'b0;
               first_q <= 1'b0;
            end
         end
         if (step) begin
            ph_q <= ph_q + 2'd1;
            case (m_st_q)
               M_START: begin
                  if (ph_q == 2'd0) m_sda_q <= 1'b0;
                  if (ph_q == 2'd1) m_sda_q <= 1'b1;
                  if (ph_q == 2'd2) m_scl_q <= 1'b1;
                  if (ph_q == 2'd3) begin
                     m_st_q <= M_IDLE;
                     first_q <= 1'b1;
                  end
               end
               M_RSTART: begin
                  if (ph_q == 2'd0) m_sda_q <= 1'b0;
                  if (ph_q == 2'd1) m_scl_q <= 1'b0;
                  if (ph_q == 2'd2) m_sda_q <= 1'b1;
                  if (ph_q == 2'd3) begin
                     m_scl_q <= 1'b1;
                     m_st_q <= M_IDLE;
                     first_q <= 1'b1;
                  end
               end
               M_STOP: begin
                  if (ph_q == 2'd0) m_sda_q <= 1'b1;
                  if (ph_q == 2'd1) m_scl_q <= 1'b0;
                  if (ph_q == 2'd2) m_sda_q <= 1'b0;
                  if (ph_q == 2'd3) m_st_q <= M_IDLE;
               end
               default: begin
                  // Data, receive and acknowledge bits share one waveform
                  if (ph_q == 2'd0) begin
                     if (m_st_q == M_TX) m_sda_q <= (m_bit_q < 4'd8) & ~m_sh_q[7];
                     else if (m_st_q == M_ACK) m_sda_q <= ~ctl_q[`B_ACK_VALUE];
                     else m_sda_q <= 1'b0;
                  end
                  if (ph_q == 2'd1) m_scl_q <= 1'b0;
                  if (ph_q == 2'd2) begin
                     m_sh_q <= {m_sh_q[6:0], sda_s};
                     if (m_st_q == M_TX && m_bit_q == 4'd8) ack_in_q <= sda_s;
                  end
                  if (ph_q == 2'd3) begin
                     m_scl_q <= 1'b1;
                     m_bit_q <= m_bit_q + 4'd1;
                     if ((m_st_q == M_TX && m_bit_q == 4'd8) || m_st_q == M_ACK
                         || (m_st_q == M_RX && m_bit_q == 4'd7)) begin
                        m_st_q <= M_IDLE;
                        m_sda_q <= 1'b0;
                     end
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Slave engine follows the synchronised lines
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         s_st_q <= S_IDLE;
         s_cnt_q <= 4'd0;
         s_sh_q <= 8'h00;
         s_sda_q <= 1'b0;
         s_rw_q <= 1'b0;
         s_match_q <= 1'b0;
         s_wide_hit_q <= 1'b0;
         s_nack_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (!en) begin
         s_st_q <= S_IDLE;
         s_sda_q <= 1'b0;
         s_wide_hit_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (run) begin
         if (start_det) begin
            s_st_q <= S_ADDR;
            s_cnt_q <= 4'd0;
            s_sda_q <= 1'b0;
            busy_q <= 1'b1;
         end else if (stop_det) begin
            s_st_q <= S_IDLE;
            s_sda_q <= 1'b0;
            s_wide_hit_q <= 1'b0;
            busy_q <= 1'b0;
         end else if (s_st_q != S_IDLE) begin
            if (scl_rise) begin
               if (s_cnt_q < 4'd8) s_sh_q <= {s_sh_q[6:0], sda_s};
               if (s_cnt_q == 4'd8) s_nack_q <= sda_s;
               s_cnt_q <= s_cnt_q + 4'd1;
            end
            if (scl_fall && s_cnt_q < 4'd8 && s_st_q == S_TX) s_sda_q <= ~s_sh_q[7 - s_cnt_q[2:0]];
            if (scl_fall && s_cnt_q == 4'd8) begin
               s_sda_q <= 1'b0;
               if (s_st_q == S_ADDR) begin
                  s_rw_q <= s_sh_q[0];
                  s_match_q <= hit7_any | (hit10 & (~s_sh_q[0] | s_wide_hit_q));
                  s_sda_q <= hit7_any | (hit10 & (~s_sh_q[0] | s_wide_hit_q));
               end
               if (s_st_q == S_ADDR2) begin
                  s_match_q <= (s_sh_q == own_q[7:0]);
                  s_sda_q <= (s_sh_q == own_q[7:0]);
               end
               if (s_st_q == S_RX) s_sda_q <= 1'b1;
            end
            if (s_bytedone) begin
               s_cnt_q <= 4'd0;
               s_sda_q <= 1'b0;
               if (!s_match_q || (s_st_q == S_TX && s_nack_q)) s_st_q <= S_IDLE;
               else if (s_st_q == S_ADDR && !s_rw_q && hit10) s_st_q <= S_ADDR2;
               else if (tx_begin) begin
                  s_st_q <= S_TX;
                  s_sh_q <= tx_q;
                  s_sda_q <= ~tx_q[7];
               end else begin
                  if (s_st_q == S_ADDR2) s_wide_hit_q <= 1'b1;
                  s_st_q <= S_RX;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Received byte holding register; reading it clears the full flag, not the byte
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         rx_q <= 8'h00;
         rx_full_q <= 1'b0;
      end else begin
         if (READ && ADDR == `OFS_RX_DATA) rx_full_q <= 1'b0;
         if (step && m_st_q == M_RX && ph_q == 2'd3 && m_bit_q == 4'd7) begin
            rx_q <= m_sh_q;
            rx_full_q <= 1'b1;
         end
         if (run && scl_fall && s_cnt_q == 4'd8 && s_st_q == S_RX) begin
            rx_q <= s_sh_q;
            rx_full_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pad drivers; open drain, so only the enables move
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         SDA_OUT <= 1'b0;
         SCL_OUT <= 1'b0;
         SDA_OE <= 1'b0;
         SCL_OE <= 1'b0;
         PINS_OWNED <= 1'b0;
         SLEW_LIMIT_OFF <= 1'b0;
         SMBUS_THRESHOLD_SELECT <= 1'b0;
      end else begin
         SDA_OUT <= 1'b0;
         SCL_OUT <= 1'b0;
         PINS_OWNED <= en;
         SDA_OE <= en & (m_sda_q | s_sda_q);
         // Hold the clock low once it is low while the slave awaits release
         SCL_OE <= en & (m_scl_q | ((s_st_q != S_IDLE) & ~ctl_q[`B_RELEASE]
                   & (~scl_s | SCL_OE)));
         SLEW_LIMIT_OFF <= ctl_q[`B_SLEW_OFF];
         SMBUS_THRESHOLD_SELECT <= ctl_q[`B_SMBUS];
      end
   end
endmodule // i2c_control_register

// File: inc/i2c_ctrl_defs.vh
`ifndef I2C_CTRL_DEFS_VH
`define I2C_CTRL_DEFS_VH
// Register offsets (byte addresses, one aligned word each)
`define OFS_CONTROL 8'h00
`define OFS_OWN_ADDR 8'h04
`define OFS_BAUD 8'h08
`define OFS_STATUS 8'h0C
`define OFS_TX_DATA 8'h10
`define OFS_RX_DATA 8'h14
// Control field positions
`define B_ENABLE 15
`define B_IDLE_STOP 13
`define B_RELEASE 12
`define B_STRICT 11
`define B_WIDE 10
`define B_SLEW_OFF 9
`define B_SMBUS 8
`define B_GC_ACCEPT 7
`define B_STRETCH 6
`define B_ACK_VALUE 5
`define B_ACK_SEND 4
`define B_RECEIVE 3
`define B_STOP 2
`define B_RSTART 1
`define B_START 0
// Reset values
`define CONTROL_RESET 16'h1000
`define BAUD_RESET 16'h0031
`endif

// File: bench/i2c_ctrl_monitor.sv
`timescale 1ns/1ps
module i2c_ctrl_monitor (
   input wire CLOCK,
   input wire RESETN,
   input wire [7:0] ADDR,
   input wire [31:0] WDATA,
   input wire WRITE,
   input wire READ,
   input wire [31:0] RDATA,
   input wire IDLE_MODE,
   input wire SDA_OE,
   input wire SCL_OE,
   input wire PINS_OWNED,
   input wire SLEW_LIMIT_OFF,
   input wire SMBUS_THRESHOLD_SELECT
);
   reg [15:0] ctl_q;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   //////////////////////////////////////////////////////////////////////////////
   // Shadow of the control word; only bits that hardware never clears are used
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ctl_q <= 16'h0000;
      end else if (WRITE && ADDR == 8'h00) begin
         ctl_q <= WDATA[15:0];
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Master start: data line falls first, then the clock line
   sequence s_start_req;
      WRITE && ADDR == 8'h00 && WDATA[15] && WDATA[0] && !IDLE_MODE;
   endsequence
   sequence s_start_walk;
      ##[1:64] SDA_OE ##[1:64] SCL_OE;
   endsequence
   sequence s_reserved_tx;
      WRITE && ADDR == 8'h10 && ctl_q[11] && WDATA[7:4] == 4'h0;
   endsequence
   sequence s_ctrl_read;
      READ && ADDR == 8'h00;
   endsequence
   // A stable shadow means the pad copy has had its one cycle to catch up
   a_pins_follow_enable: assert property ($stable(ctl_q[15]) |-> PINS_OWNED == ctl_q[15])
      else $error("pin ownership does not follow enable");
   a_lines_free_off: assert property (!ctl_q[15] && !$past(ctl_q[15]) |-> !SDA_OE && !SCL_OE)
      else $error("lines driven while disabled");
   a_slew_follows_bit: assert property ($stable(ctl_q[9]) |-> SLEW_LIMIT_OFF == ctl_q[9])
      else $error("slew pad control wrong");
   a_smbus_follows_bit: assert property ($stable(ctl_q[8]) |-> SMBUS_THRESHOLD_SELECT == ctl_q[8])
      else $error("threshold pad control wrong");
   a_idle_freeze: assert property (ctl_q[13] && IDLE_MODE && $past(IDLE_MODE) |-> $stable({SDA_OE, SCL_OE}))
      else $error("lines moved while halted in idle");
   a_ctrl_zero_bits: assert property (s_ctrl_read |=> RDATA[31:16] == 16'h0000 && !RDATA[14])
      else $error("unimplemented control bits not zero");
   a_start_sequence: assert property (s_start_req |-> s_start_walk)
      else $error("start condition not produced");
   a_strict_no_send: assert property (s_reserved_tx |=> $stable({SDA_OE, SCL_OE}) [*8])
      else $error("reserved address sent in strict mode");
endmodule // i2c_ctrl_monitor
bind i2c_control_register i2c_ctrl_monitor i2c_ctrl_monitor_inst (.CLOCK(CLOCK), .RESETN(RESETN),
   .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA), .IDLE_MODE(IDLE_MODE),
   .SDA_OE(SDA_OE), .SCL_OE(SCL_OE), .PINS_OWNED(PINS_OWNED), .SLEW_LIMIT_OFF(SLEW_LIMIT_OFF),
   .SMBUS_THRESHOLD_SELECT(SMBUS_THRESHOLD_SELECT));

// File: bench/bus_partner.sv
`timescale 1ns/1ps
module bus_partner (
   input wire sda,
   input wire scl,
   output reg sda_pull,
   output reg scl_pull
);
   integer i;
   integer n;
   initial begin
      sda_pull = 1'b0;
      scl_pull = 1'b0;
   end
   //////////////////////////////////////////////////////////////////////////////
   // Clock line high phase; waits while a target stretches it, bounded
   task rise_scl;
      begin
         scl_pull = 1'b0;
         n = 0;
         while (scl !== 1'b1 && n < 2000) begin
            #10;
            n = n + 1;
         end
         #80;
      end
   endtask
   task start_cond;
      begin
         sda_pull = 1'b0;
         #80;
         rise_scl;
         sda_pull = 1'b1;
         #80;
         scl_pull = 1'b1;
      end
   endtask
   task stop_cond;
      begin
         sda_pull = 1'b1;
         #80;
         rise_scl;
         sda_pull = 1'b0;
         #80;
      end
   endtask
   task let_go;
      begin
         sda_pull = 1'b0;
         scl_pull = 1'b0;
      end
   endtask
   // Eight bits MSB first; the ninth clock samples the acknowledge at its end
   task send_byte(input [7:0] b, output ack);
      begin
         for (i = 0; i < 9; i = i + 1) begin
            sda_pull = (i < 8) ? ~b[7 - i] : 1'b0;
            #80;
            rise_scl;
            if (i == 8) ack = sda;
            scl_pull = 1'b1;
         end
      end
   endtask
endmodule // bus_partner

// File: bench/i2c_control_register_tb.sv
`timescale 1ns/1ps
module i2c_control_register_tb;
   reg CLOCK, RESETN, WRITE, READ, IDLE_MODE;
   reg [7:0] ADDR;
   reg [31:0] WDATA;
   reg [31:0] d;
   reg ack;
   integer error_cnt, n_compared, k;
   wire [31:0] RDATA;
   wire SDA_OUT, SDA_OE, SCL_OUT, SCL_OE, PINS_OWNED, SLEW_LIMIT_OFF, SMBUS_THRESHOLD_SELECT;
   wire sda_pull, scl_pull;
   // Open-drain lines with pull-ups
   wire sda = ~SDA_OE & ~sda_pull;
   wire scl = ~SCL_OE & ~scl_pull;
   i2c_control_register i2c_control_register_inst (.CLOCK(CLOCK), .RESETN(RESETN), .ADDR(ADDR),
      .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA), .IDLE_MODE(IDLE_MODE),
      .SDA_IN(sda), .SCL_IN(scl), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SCL_OUT(SCL_OUT),
      .SCL_OE(SCL_OE), .PINS_OWNED(PINS_OWNED), .SLEW_LIMIT_OFF(SLEW_LIMIT_OFF),
      .SMBUS_THRESHOLD_SELECT(SMBUS_THRESHOLD_SELECT));
   bus_partner bus_partner_inst (.sda(sda), .scl(scl), .sda_pull(sda_pull), .scl_pull(scl_pull));
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   // Every access leaves one idle cycle behind it, which also keeps clear of a disable
   task wr(input [7:0] a, input [31:0] v);
      begin
         @(posedge CLOCK);
         ADDR <= a;
         WDATA <= v;
         WRITE <= 1'b1;
         @(posedge CLOCK);
         WRITE <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, output [31:0] v);
      begin
         @(posedge CLOCK);
         ADDR <= a;
         READ <= 1'b1;
         @(posedge CLOCK);
         READ <= 1'b0;
         #1 v = RDATA;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp, input [127:0] what);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t ns: %0s", $time, what);
         end
      end
   endtask
   // Polls the control word until the given sequence bits drop, bounded
   task wait_clear(input [31:0] mask);
      integer t;
      begin
         t = 0;
         d = mask;
         while ((d & mask) != 32'h0000_0000 && t < 100) begin
            rd(8'h00, d);
            t = t + 1;
         end
      end
   endtask
   task end_of_test;
      begin
         $display("compared %0d, mismatches %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      end_of_test;
   end
   initial begin
      error_cnt = 0;
      n_compared = 0;
      {RESETN, WRITE, READ, IDLE_MODE, ADDR, WDATA} = 0;
      repeat (8) @(posedge CLOCK);
      RESETN <= 1'b1;
      rd(8'h00, d);
      chk(d, 32'h0000_1000, "ctrl reset");
      rd(8'h20, d);
      chk(d, 32'h0000_0000, "unmapped read");
      wr(8'h00, 32'hFFFF_4000);
      rd(8'h00, d);
      chk(d, 32'h0000_1000, "reserved bits");
      wr(8'h00, 32'h0000_9300);
      repeat (3) @(posedge CLOCK);
      chk({29'd0, PINS_OWNED, SLEW_LIMIT_OFF, SMBUS_THRESHOLD_SELECT}, 32'h7, "pads on");
      wr(8'h00, 32'h0000_1000);
      repeat (3) @(posedge CLOCK);
      chk({27'd0, PINS_OWNED, SLEW_LIMIT_OFF, SMBUS_THRESHOLD_SELECT, SDA_OE, SCL_OE}, 0, "off");
      wr(8'h00, 32'h0000_8000);
      rd(8'h00, d);
      chk(d & 32'h0000_1000, 32'h0000_1000, "release kept");
      wr(8'h00, 32'h0000_8040);
      wr(8'h00, 32'h0000_8040); // Stretch now on, so the zero lands
      rd(8'h00, d);
      chk(d & 32'h0000_1000, 32'h0000_0000, "release stretch");
      $display("test registers done");
      wr(8'h08, 32'h0000_0004);
      wr(8'h00, 32'h0000_B801);
      wait_clear(32'h0000_0001);
      chk({d[0], SDA_OE, SCL_OE}, 32'h3, "start walk");
      wr(8'h10, 32'h0000_000C);
      repeat (20) @(posedge CLOCK);
      rd(8'h0C, d);
      chk(d & 32'h0000_0020, 32'h0000_0020, "strict refusal");
      IDLE_MODE <= 1'b1;
      wr(8'h00, 32'h0000_B804);
      repeat (60) @(posedge CLOCK);
      rd(8'h00, d);
      chk(d & 32'h0000_0004, 32'h0000_0004, "idle halt");
      IDLE_MODE <= 1'b0;
      wait_clear(32'h0000_0004);
      chk({d[2], SDA_OE, SCL_OE}, 32'h0, "stop walk");
      $display("test master done");
      wr(8'h04, 32'h0000_002A);
      // Stretch on: end of a received byte must drop the release bit
      wr(8'h00, 32'h0000_9040);
      bus_partner_inst.start_cond;
      bus_partner_inst.send_byte(8'h54, ack);
      bus_partner_inst.send_byte(8'hA5, ack);
      repeat (20) @(posedge CLOCK);
      rd(8'h00, d);
      chk({d[12], ack, SCL_OE}, 32'h1, "rx end stretch");
      rd(8'h14, d);
      chk(d, 32'h0000_00A5, "rx byte");
      wr(8'h00, 32'h0000_9040);
      bus_partner_inst.stop_cond;
      for (k = 0; k < 4; k = k + 1) begin
         wr(8'h00, (k == 0) ? 32'h9880 : (k == 1) ? 32'h9080 : (k == 2) ? 32'h9400 : 32'h9000);
         bus_partner_inst.start_cond;
         bus_partner_inst.send_byte((k < 2) ? 8'h00 : 8'h54, ack);
         chk({31'd0, ack}, {31'd0, ~k[0]}, "address ack");
         bus_partner_inst.stop_cond;
      end
      bus_partner_inst.start_cond;
      bus_partner_inst.send_byte(8'h55, ack);
      repeat (20) @(posedge CLOCK);
      rd(8'h00, d);
      chk({d[12], ack, SCL_OE}, 32'h1, "slave hold");
      wr(8'h00, 32'h0000_9000);
      repeat (4) @(posedge CLOCK);
      chk({31'd0, SCL_OE}, 32'h0, "slave release");
      $display("test slave done");
      RESETN <= 1'b0;
      bus_partner_inst.let_go;
      repeat (3) @(posedge CLOCK);
      RESETN <= 1'b1;
      rd(8'h00, d);
      chk(d, 32'h0000_1000, "second reset");
      $display("test reset done");
      end_of_test;
   end
endmodule // i2c_control_register_tb
